/* logic/ssbc_pkg.sv */
package ssbc_pkg;

  // divider field codes, width and limits of the usable range
  localparam int unsigned RATE_W        = 3;
  localparam logic [2:0]  RATE_CODE_MIN = 3'h1;  // divide by 4
  localparam logic [2:0]  RATE_CODE_MAX = 3'h6;  // divide by 128

  // half-period counter: half period is one shifted left by the code
  localparam int unsigned HALF_W   = 7;
  localparam logic [6:0]  HALF_ONE = 7'h01;
  localparam logic [6:0]  CNT_STEP = 7'h01;

  // one byte is sixteen serial clock edges
  localparam int unsigned EDGE_W     = 5;
  localparam logic [4:0]  XFER_EDGES = 5'h10;
  localparam logic [4:0]  EDGE_STEP  = 5'h01;

  // reset values
  localparam logic        SCK_IDLE   = 1'b0;
  localparam logic        SS_IDLE    = 1'b1;  // select pin idles high

  // master transfer sequencer
  typedef enum logic [0:0] {
    SSBC_IDLE,
    SSBC_RUN
  } ssbc_state_e;

endpackage : ssbc_pkg

/* logic/ssbc_rate_gen.sv */
module ssbc_rate_gen
  import ssbc_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // control
  input  wire logic                      run,
  input  wire logic [ssbc_pkg::RATE_W-1:0] rate_divisor,
  // results
  output logic                           tick,
  output logic                           rate_valid
);

  // whole state of the generator
  typedef struct packed {
    logic [HALF_W-1:0] cnt;  // cycles spent in this half period
  } ssbc_rg_s;

  ssbc_rg_s          q_r;   // registered state
  ssbc_rg_s          q_nxt; // next state
  logic [HALF_W-1:0] half;  // half period in clock cycles

  // codes 000 and 111 have no generator behind them
  assign rate_valid = (rate_divisor >= RATE_CODE_MIN) && (rate_divisor <= RATE_CODE_MAX);
  // half of divisor 4..128 is 2..64 cycles
  assign half = HALF_ONE << rate_divisor;
  assign tick = run && rate_valid && (q_r.cnt == (half - CNT_STEP));

  // count only while a transfer runs, so each one starts on a whole half period
  always_comb begin
    q_nxt = q_r;
    if (!run || !rate_valid || tick) begin
      q_nxt.cnt = '0;
    end else begin
      q_nxt.cnt = q_r.cnt + CNT_STEP;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ticks never come from an unusable code
  chk_no_rate_bad: assert property (@(posedge clk) disable iff (rst)
    tick |-> (rate_divisor != 3'h0) && (rate_divisor != 3'h7))
    else $error("tick produced for an unusable divider code");

  // divide by four: a tick every second cycle
  chk_div4_spacing: assert property (@(posedge clk) disable iff (rst)
    (tick && rate_divisor == 3'h1) ##1 (run && rate_divisor == 3'h1)
      |-> !tick ##1 (!run || rate_divisor != 3'h1 || tick))
    else $error("divide-by-four half period is not two cycles");

  // divide by 128: no tick on the eighth cycle after the last one
  chk_div128_gap: assert property (@(posedge clk) disable iff (rst)
    (tick && rate_divisor == 3'h6) ##1 (run && rate_divisor == 3'h6)[*8] |-> !tick)
    else $error("divide-by-128 half period too short");

endmodule : ssbc_rate_gen

/* logic/ssbc_top.sv */
// How it works
// - select input plus fault flag stop master driving
// - slave tri-states output data when select high, unless phase one and select disabled force selection
// - master with select disabled: pin free, no fault
// - slave, phase one, select disabled: always selected
// - clearing select disable keeps fault flag
// - phase zero slave ignores select disable
// - master clock from three-bit divider field
// - codes 1..6 divide by 4..128; others unusable
module ssbc_top
  import ssbc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // configuration from the processor
  input  wire logic master_mode,
  input  wire logic select_input_disable,
  input  wire logic clock_phase_select,
  input  wire logic rate_select_bit2,
  input  wire logic rate_select_bit1,
  input  wire logic rate_select_bit0,
  // transfer control and fault handling
  input  wire logic xfer_start,
  input  wire logic mode_fault_clear,
  // pins
  input  wire logic ss_n_pin,
  output logic      sck_out,
  output logic      sck_oe,
  output logic      mosi_oe,
  output logic      miso_oe,
  // status
  output logic      mode_fault_flag,
  output logic      xfer_busy,
  output logic      xfer_done,
  output logic      slave_selected,
  output logic      ss_gpio_free,
  output logic      rate_valid
);

  // whole state of the block
  typedef struct packed {
    ssbc_state_e       state;    // sequencer state
    logic              sck;      // serial clock level
    logic [EDGE_W-1:0] edges;    // clock edges issued so far
    logic              fault;    // sticky mode fault
    logic              done;     // one-cycle end of transfer
    logic              ss_meta;  // first synchroniser stage
    logic              ss_sync;  // second synchroniser stage
  } ssbc_s;

  ssbc_s             q_r;        // registered state
  ssbc_s             q_nxt;      // next state
  logic [RATE_W-1:0] rate_divisor; // assembled divider field
  logic              tick;       // half period elapsed
  logic              ss_low;     // select pin low after sync
  logic              fault_set;  // fault condition this cycle
  logic              run;        // generator enable

  assign rate_divisor = {rate_select_bit2, rate_select_bit1, rate_select_bit0};
  assign ss_low       = !q_r.ss_sync;

  // another master pulling select low while we are master is a fault,
  // unless the select input is disabled and the pin is a plain port
  assign fault_set = master_mode && !select_input_disable && ss_low;

  assign run = (q_r.state == SSBC_RUN);

  // divider shared by every transfer
  ssbc_rate_gen u_rate_gen (
    .clk          (clk),
    .rst          (rst),
    .run          (run),
    .rate_divisor (rate_divisor),
    .tick         (tick),
    .rate_valid   (rate_valid)
  );

  // next-state logic: synchroniser, fault flag and transfer sequencer
  always_comb begin
    q_nxt         = q_r;
    q_nxt.ss_meta = ss_n_pin;
    q_nxt.ss_sync = q_r.ss_meta;
    q_nxt.done    = 1'b0;
    // the set wins over a clear in the same cycle; only the explicit
    // clear input drops the flag, the select-disable bit never does
    q_nxt.fault   = fault_set || (q_r.fault && !mode_fault_clear);
    unique case (q_r.state)
      SSBC_IDLE: begin
        q_nxt.sck   = SCK_IDLE;
        q_nxt.edges = '0;
        // unusable divider codes simply never start a transfer
        if (xfer_start && master_mode && rate_valid && !q_r.fault && !fault_set) begin
          q_nxt.state = SSBC_RUN;
        end
      end
      SSBC_RUN: begin
        if (fault_set || !master_mode) begin
          // abort at once so two masters never fight on the clock line
          q_nxt.state = SSBC_IDLE;
          q_nxt.sck   = SCK_IDLE;
        end else if (tick) begin
          q_nxt.sck   = !q_r.sck;
          q_nxt.edges = q_r.edges + EDGE_STEP;
          if (q_r.edges == (XFER_EDGES - EDGE_STEP)) begin
            q_nxt.state = SSBC_IDLE;
            q_nxt.done  = 1'b1;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r.state   <= SSBC_IDLE;
      q_r.sck     <= SCK_IDLE;
      q_r.edges   <= '0;
      q_r.fault   <= 1'b0;
      q_r.done    <= 1'b0;
      q_r.ss_meta <= SS_IDLE;
      q_r.ss_sync <= SS_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // slave selection: forced on only when phase is one, because with phase
  // zero the select edge itself starts the slave's transfer
  assign slave_selected = ss_low || (clock_phase_select && select_input_disable);

  // a master with a pending fault lets go of its clock and data lines
  assign sck_oe  = master_mode && !q_r.fault;
  assign mosi_oe = master_mode && !q_r.fault;
  // a slave only drives its data line while selected
  assign miso_oe = !master_mode && slave_selected;

  // pin available as general-purpose port
  assign ss_gpio_free = select_input_disable && (master_mode || clock_phase_select);

  assign sck_out         = q_r.sck;
  assign mode_fault_flag = q_r.fault;
  assign xfer_busy       = run;
  assign xfer_done       = q_r.done;

  // a pending fault keeps the master's outputs released
  chk_fault_release: assert property (@(posedge clk) disable iff (rst)
    mode_fault_flag |-> !sck_oe && !mosi_oe)
    else $error("master drives lines while mode fault is set");

  // slave with select high and no forced selection floats its data line
  chk_miso_float: assert property (@(posedge clk) disable iff (rst)
    (!master_mode && q_r.ss_sync && !(clock_phase_select && select_input_disable))
      |-> !miso_oe)
    else $error("slave drives data while deselected");

  // select-disabled master never raises a fault
  chk_no_fault_dis: assert property (@(posedge clk) disable iff (rst)
    (master_mode && select_input_disable && !mode_fault_flag) |=> !mode_fault_flag)
    else $error("fault set while select input disabled");

  // phase one and disable keep the slave selected whatever the pin does
  chk_forced_select: assert property (@(posedge clk) disable iff (rst)
    (!master_mode && clock_phase_select && select_input_disable) |-> slave_selected && miso_oe)
    else $error("slave not permanently selected");

  // dropping select disable alone leaves the fault flag standing
  chk_fault_sticky: assert property (@(posedge clk) disable iff (rst)
    (mode_fault_flag && !mode_fault_clear) |=> mode_fault_flag)
    else $error("fault flag lost without a clear");

  // select low in master mode raises the fault three cycles after the pin
  chk_fault_raise: assert property (@(posedge clk) disable iff (rst)
    (master_mode && !select_input_disable && !ss_n_pin) ##1
    (master_mode && !select_input_disable && !ss_n_pin) ##1
    (master_mode && !select_input_disable) |=> mode_fault_flag)
    else $error("fault flag not raised on select low");

  // serial clock stays idle outside a transfer
  chk_sck_idle: assert property (@(posedge clk) disable iff (rst)
    !xfer_busy |=> (!xfer_busy || $stable(sck_out)) && (xfer_busy || !sck_out))
    else $error("serial clock moved while idle");

  // outside an abort, the clock changes only on a generator tick
  chk_sck_on_tick: assert property (@(posedge clk) disable iff (rst)
    (xfer_busy && !tick && !fault_set && master_mode) |=> $stable(sck_out))
    else $error("serial clock toggled without a divider tick");

  // a finished transfer ends with the clock back at idle
  chk_done_idle: assert property (@(posedge clk) disable iff (rst)
    xfer_done |-> !xfer_busy && (sck_out == SCK_IDLE))
    else $error("transfer ended with clock not idle");

  // leaving master mode in mid-transfer drops it at once, with no done pulse
  chk_mode_abort: assert property (@(posedge clk) disable iff (rst)
    (xfer_busy && !master_mode) |=> !xfer_busy && !xfer_done)
    else $error("transfer kept running after leaving master mode");

  // a pending fault refuses every new start
  chk_start_blocked: assert property (@(posedge clk) disable iff (rst)
    (!xfer_busy && mode_fault_flag) |=> !xfer_busy)
    else $error("transfer started while mode fault pending");

  // end of transfer is a single-cycle pulse
  chk_done_single: assert property (@(posedge clk) disable iff (rst)
    xfer_done |=> !xfer_done)
    else $error("done pulse longer than one cycle");

  // a transfer only starts from a usable divider code
  chk_start_rate: assert property (@(posedge clk) disable iff (rst)
    $rose(xfer_busy) |-> $past(rate_valid))
    else $error("transfer started with an unusable divider code");

  // main scenarios
  cov_full_xfer: cover property (@(posedge clk) disable iff (rst)
    $rose(xfer_busy) ##[1:300] xfer_done);
  cov_fault_abort: cover property (@(posedge clk) disable iff (rst)
    xfer_busy ##1 $rose(mode_fault_flag));
  cov_forced_slave: cover property (@(posedge clk) disable iff (rst)
    (!master_mode && ss_gpio_free && miso_oe));
  cov_mode_abort: cover property (@(posedge clk) disable iff (rst)
    (xfer_busy && !master_mode));

endmodule : ssbc_top

/* bench/ssbc_peer_model.sv */
module ssbc_peer_model (
  // bench command: another party pulls the select line low
  input  wire logic grab,
  // select line seen by the block
  output logic      ss_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // a released line returns to its pull-up level, never the last driven value
  always_comb begin
    ss_n = grab ? 1'h0 : 1'h1;
  end
  // this party makes no serial clock, so it never exceeds a quarter of clk
endmodule : ssbc_peer_model

/* bench/ssbc_tb_top.sv */
module ssbc_tb_top
  import ssbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // stimulus, all given a value at time zero
  logic       clk = 1'h0, rst = 1'h1, master_mode = 1'h1, grab = 1'h0;
  logic       select_input_disable = 1'h0, clock_phase_select = 1'h0;
  logic       xfer_start = 1'h0, mode_fault_clear = 1'h0;
  logic [2:0] rate = 3'h1;
  // observed outputs
  logic       ss_n_pin, sck_out, sck_oe, mosi_oe, miso_oe, mode_fault_flag;
  logic       xfer_busy, xfer_done, slave_selected, ss_gpio_free, rate_valid;
  int         miscompares = 0, n_checks = 0, cycles = 0;

  ssbc_peer_model peer_u (.grab, .ss_n(ss_n_pin));
  ssbc_top dut_u (.clk, .rst, .master_mode, .select_input_disable, .clock_phase_select,
    .rate_select_bit2(rate[2]), .rate_select_bit1(rate[1]), .rate_select_bit0(rate[0]),
    .xfer_start, .mode_fault_clear, .ss_n_pin, .sck_out, .sck_oe, .mosi_oe, .miso_oe,
    .mode_fault_flag, .xfer_busy, .xfer_done, .slave_selected, .ss_gpio_free, .rate_valid);

  // 100 ns period
  always #50 clk = ~clk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // one master transfer at a divider code; unusable codes must be refused
  task automatic t_rate(input logic [2:0] code);
    int   n;
    int   tg;
    logic last;
    logic ok;
    ok = (code >= 3'h1 && code <= 3'h6);
    rate = code;
    xfer_start = 1'h1;
    step(1);
    xfer_start = 1'h0;
    chk(rate_valid, ok, "rate valid flag");
    n = 0;
    while (xfer_busy !== 1'h1 && n < 4) begin
      step(1);
      n++;
    end
    chk(xfer_busy, ok, "busy after start");
    if (xfer_busy === 1'h1) begin
      n = 0;
      tg = 0;
      last = sck_out;
      while (xfer_done !== 1'h1 && n < 1100) begin
        step(1);
        n++;
        if (sck_out !== last) tg++;
        last = sck_out;
      end
      chk(n == (16 << code), 1'h1, "transfer length");
      chk(tg == 16, 1'h1, "clock edge count");
      chk(xfer_busy, 1'h0, "busy after done");
      step(1);
      chk(xfer_done, 1'h0, "done lasts one cycle");
    end
    step(4);
    chk(sck_out, SCK_IDLE, "clock idle between transfers");
  endtask : t_rate

  // a rival master pulls select low in mid-transfer
  task automatic t_fault;
    xfer_start = 1'h1;
    step(1);
    xfer_start = 1'h0;
    step(3);
    grab = 1'h1;
    step(2);
    chk(mode_fault_flag, 1'h0, "fault too early");
    step(1);
    chk(mode_fault_flag, 1'h1, "fault not set");
    chk(sck_oe | mosi_oe, 1'h0, "drivers still on");
    step(1);
    chk(xfer_busy | xfer_done, 1'h0, "transfer not aborted");
    grab = 1'h0;
    xfer_start = 1'h1;
    step(1);
    xfer_start = 1'h0;
    select_input_disable = 1'h1;
    step(3);
    chk(xfer_busy, 1'h0, "start taken under fault");
    select_input_disable = 1'h0;
    step(3);
    chk(mode_fault_flag, 1'h1, "fault lost on disable clear");
    mode_fault_clear = 1'h1;
    step(1);
    mode_fault_clear = 1'h0;
    chk(mode_fault_flag, 1'h0, "fault not cleared");
    chk(sck_oe & mosi_oe, 1'h1, "drivers not back");
  endtask : t_fault

  // master with select disabled: pin is free and low level is harmless
  task automatic t_gpio;
    select_input_disable = 1'h1;
    grab = 1'h1;
    step(6);
    chk(mode_fault_flag, 1'h0, "fault with select disabled");
    chk(ss_gpio_free, 1'h1, "pin not free");
    grab = 1'h0;
    // let the synchroniser see the pin high before the select input counts again
    step(4);
    select_input_disable = 1'h0;
    step(2);
    chk(mode_fault_flag, 1'h0, "fault after pin released");
  endtask : t_gpio

  // slave selection and data output enable
  task automatic t_slave;
    master_mode = 1'h0;
    step(4);
    chk(miso_oe | slave_selected, 1'h0, "output on while deselected");
    grab = 1'h1;
    step(4);
    chk(miso_oe & slave_selected, 1'h1, "output off while selected");
    grab = 1'h0;
    clock_phase_select = 1'h1;
    select_input_disable = 1'h1;
    step(4);
    chk(miso_oe & slave_selected & ss_gpio_free, 1'h1, "not always selected");
    clock_phase_select = 1'h0;
    step(1);
    chk(slave_selected | miso_oe, 1'h0, "phase zero forced select");
    chk(ss_gpio_free, 1'h0, "phase zero slave pin freed");
    master_mode = 1'h1;
    select_input_disable = 1'h0;
    step(4);
  endtask : t_slave

  // leaving master mode, then a reset, each in mid-transfer
  task automatic t_abort;
    xfer_start = 1'h1;
    step(1);
    xfer_start = 1'h0;
    step(5);
    chk(xfer_busy, 1'h1, "transfer not running");
    master_mode = 1'h0;
    step(1);
    chk(xfer_busy | xfer_done | sck_out, 1'h0, "no abort on slave mode");
    master_mode = 1'h1;
    xfer_start = 1'h1;
    step(1);
    xfer_start = 1'h0;
    step(5);
    rst = 1'h1;
    step(2);
    rst = 1'h0;
    chk(xfer_busy | xfer_done | sck_out | mode_fault_flag, 1'h0, "reset in mid-run");
    step(2);
    chk(xfer_busy | sck_out, 1'h0, "activity after reset");
  endtask : t_abort

  // main sequence
  initial begin
    step(10);
    rst = 1'h0;
    chk(mode_fault_flag | xfer_busy | xfer_done | sck_out, 1'h0, "reset values");
    for (int c = 0; c < 8; c++) t_rate(3'(c));
    rate = 3'h1;
    t_fault();
    t_gpio();
    t_slave();
    t_abort();
    wrap_up();
  end
endmodule : ssbc_tb_top
